// File: vdirq_ctrl.sv
`timescale 1ns/1ns
// Behaviour
// - acknowledge drives programmed vector onto bus
// - channel A plain vector, B with status
// - six sources: pending, in-service, enable bits
// - request needs source and global enable
// - source enables are write-only
// - request low when pending and chain-in high
// - disabled source never sets pending
// - all pending bits readable in one register
// - in-service blocks lower sources, chain out low
// - acknowledge sets highest pending in-service bit
// - A over B; rx over tx over ext
// - acknowledge releases request output
// - three selectable receive interrupt modes
// - special conditions differ only in vector status
// - first-char mode allows specials after first
// - ext/status requests on listed transitions and events
// - abort/end-of-poll interrupts at start and end
// - software acknowledge on vector read when enabled
// - software acknowledge ignores status/no-vector settings
// - status updated automatically for polling
// - chain out high only when idle and chain-in
// - acknowledge sampled on rising clock edge
// - vector driven when read strobe and chain-in
module vdirq_ctrl (
   input wire logic clk_sys_in,
   input wire logic reset_n_in,
   input wire logic [7:0] vector_write_in,
   input wire logic vector_write_stb_in,
   input wire logic [7:0] master_ctrl_in,
   input wire logic master_ctrl_stb_in,
   input wire logic [5:0] source_enable_in,
   input wire logic source_enable_stb_in,
   input wire vdirq_pkg::vdirq_rx_mode_t rx_mode_a_in,
   input wire vdirq_pkg::vdirq_rx_mode_t rx_mode_b_in,
   input wire vdirq_pkg::vdirq_chan_evt_t evt_a_in,
   input wire vdirq_pkg::vdirq_chan_evt_t evt_b_in,
   input wire vdirq_pkg::vdirq_chan_clr_t clr_a_in,
   input wire vdirq_pkg::vdirq_chan_clr_t clr_b_in,
   input wire logic reset_highest_stb_in,
   input wire logic vector_read_stb_in,
   input wire logic vector_read_chan_b_in,
   input wire logic irq_ack_n_in,
   input wire logic rd_n_in,
   input wire logic chain_enable_in,
   output logic irq_n_out,
   output logic irq_n_oe_out,
   output logic chain_enable_out,
   output logic [7:0] data_out,
   output logic data_oe_out,
   output logic [7:0] vector_read_out,
   output logic [5:0] pending_read_out,
   output logic [5:0] in_service_out,
   output logic [1:0] rx_avail_out
);
   localparam int N = vdirq_pkg::NUM_SRC;
   logic [7:0] vector_q, vector_d;
   logic [7:0] mctl_q, mctl_d;
   logic [N-1:0] enable_q, enable_d;
   logic [N-1:0] pending_q, pending_d;
   logic [N-1:0] ius_q, ius_d;
   logic [1:0] special_q, special_d;
   logic [1:0] first_done_q, first_done_d;
   logic ack_q, ack_d;
   logic ack_prev_q, ack_prev_d;
   logic [7:0] dout_q, dout_d;
   logic [7:0] vrd_q, vrd_d;
   logic [N-1:0] set_evt, clr_evt, grant, served, clr_ius;
   logic [N-1:0] req_gate;
   logic [1:0] rx_fire, spc_fire;
   logic ext_a, ext_b;
   logic blocked;
   logic ack_start;
   logic sw_ack;
   logic [2:0] stat;
   logic [7:0] vec_mod;

   function automatic logic rx_ok(input vdirq_pkg::vdirq_rx_mode_t m, input logic done);
      rx_ok = (m == vdirq_pkg::VDIRQ_RX_ALL) || (m == vdirq_pkg::VDIRQ_RX_FIRST && !done);
   endfunction

   function automatic logic spc_ok(input vdirq_pkg::vdirq_rx_mode_t m, input logic done);
      spc_ok = (m == vdirq_pkg::VDIRQ_RX_ALL) || (m == vdirq_pkg::VDIRQ_RX_SPECIAL)
         || (m == vdirq_pkg::VDIRQ_RX_FIRST && done);
   endfunction

   always_comb begin
      // receive mode filtering
      rx_fire[0] = evt_a_in.rx_char && rx_ok(rx_mode_a_in, first_done_q[0]);
      rx_fire[1] = evt_b_in.rx_char && rx_ok(rx_mode_b_in, first_done_q[1]);
      spc_fire[0] = evt_a_in.rx_special && spc_ok(rx_mode_a_in, first_done_q[0]);
      spc_fire[1] = evt_b_in.rx_special && spc_ok(rx_mode_b_in, first_done_q[1]);
      // ext/status sources; abort/eop at both ends
      ext_a = evt_a_in.cts_edge | evt_a_in.dcd_edge | evt_a_in.sync_edge
         | evt_a_in.tx_underrun | evt_a_in.baud_zero
         | evt_a_in.brk_abort_eop_start | evt_a_in.brk_abort_eop_end;
      ext_b = evt_b_in.cts_edge | evt_b_in.dcd_edge | evt_b_in.sync_edge
         | evt_b_in.tx_underrun | evt_b_in.baud_zero
         | evt_b_in.brk_abort_eop_start | evt_b_in.brk_abort_eop_end;
   end

   always_comb begin
      // source events into per-source set and clear vectors
      set_evt = '0;
      set_evt[vdirq_pkg::SRC_A_RX] = rx_fire[0] | spc_fire[0];
      set_evt[vdirq_pkg::SRC_A_TX] = evt_a_in.tx_empty;
      set_evt[vdirq_pkg::SRC_A_EXT] = ext_a;
      set_evt[vdirq_pkg::SRC_B_RX] = rx_fire[1] | spc_fire[1];
      set_evt[vdirq_pkg::SRC_B_TX] = evt_b_in.tx_empty;
      set_evt[vdirq_pkg::SRC_B_EXT] = ext_b;
      clr_evt = '0;
      clr_evt[vdirq_pkg::SRC_A_RX] = clr_a_in.rx_clear;
      clr_evt[vdirq_pkg::SRC_A_TX] = clr_a_in.tx_clear;
      clr_evt[vdirq_pkg::SRC_A_EXT] = clr_a_in.ext_clear;
      clr_evt[vdirq_pkg::SRC_B_RX] = clr_b_in.rx_clear;
      clr_evt[vdirq_pkg::SRC_B_TX] = clr_b_in.tx_clear;
      clr_evt[vdirq_pkg::SRC_B_EXT] = clr_b_in.ext_clear;

   end

   always_comb begin
      // internal daisy chain: any in-service or pending source blocks only those below it
      req_gate = '0;
      blocked = 1'b0;
      grant = '0;
      for (int i = 0; i < N; i++) begin
         if (!blocked && pending_q[i]) begin
            grant[i] = 1'b1;
         end
         req_gate[i] = pending_q[i] && !blocked;
         if (ius_q[i] || (pending_q[i] && !blocked)) begin
            blocked = 1'b1;
         end
      end
      if (!mctl_q[vdirq_pkg::MCTL_MIE_BIT]) begin
         req_gate = '0;
         grant = '0;
      end

   end

   always_comb begin
      // acknowledge: hardware on falling sampled edge, or software vector read
      ack_d = !irq_ack_n_in;
      ack_prev_d = ack_q;
      ack_start = ack_q && !ack_prev_q;
      sw_ack = vector_read_stb_in && mctl_q[vdirq_pkg::MCTL_SWACK_BIT];
      served = ((ack_start && chain_enable_in) || sw_ack) ? grant : '0;

   end

   always_comb begin
      // last hit of the downward scan is the highest in-service bit
      clr_ius = '0;
      if (reset_highest_stb_in) begin
         for (int i = N - 1; i >= 0; i--) begin
            if (ius_q[i]) begin
               clr_ius = '0;
               clr_ius[i] = 1'b1;
            end
         end
      end

      // pending: set wins over clear, serviced source drops its request
      pending_d = ((pending_q & ~clr_evt & ~served) | set_evt) & enable_q;
      ius_d = (ius_q & ~clr_ius) | served;
      enable_d = source_enable_stb_in ? source_enable_in : enable_q;
      vector_d = vector_write_stb_in ? vector_write_in : vector_q;
      mctl_d = master_ctrl_stb_in ? master_ctrl_in : mctl_q;

   end

   always_comb begin
      special_d = special_q;
      first_done_d = first_done_q;
      if (spc_fire[0]) begin
         special_d[0] = 1'b1;
      end else if (rx_fire[0]) begin
         special_d[0] = 1'b0;
      end
      if (spc_fire[1]) begin
         special_d[1] = 1'b1;
      end else if (rx_fire[1]) begin
         special_d[1] = 1'b0;
      end
      // a character in the same cycle as the re-arm wins
      if (clr_a_in.first_rearm) begin
         first_done_d[0] = 1'b0;
      end
      if (rx_fire[0]) begin
         first_done_d[0] = 1'b1;
      end
      if (clr_b_in.first_rearm) begin
         first_done_d[1] = 1'b0;
      end
      if (rx_fire[1]) begin
         first_done_d[1] = 1'b1;
      end
   end

   always_comb begin

      // vector status from highest pending source
      unique casez (grant)
         6'b?????1: stat = special_q[0] ? vdirq_pkg::VSTAT_A_SPC : vdirq_pkg::VSTAT_A_RX;
         6'b????10: stat = vdirq_pkg::VSTAT_A_TX;
         6'b???100: stat = vdirq_pkg::VSTAT_A_EXT;
         6'b??1000: stat = special_q[1] ? vdirq_pkg::VSTAT_B_SPC : vdirq_pkg::VSTAT_B_RX;
         6'b?10000: stat = vdirq_pkg::VSTAT_B_TX;
         6'b100000: stat = vdirq_pkg::VSTAT_B_EXT;
         default: stat = vdirq_pkg::VSTAT_NONE;
      endcase
      vec_mod = vector_q;
      vec_mod[vdirq_pkg::VSTAT_LSB +: vdirq_pkg::VSTAT_W] = stat;
      vrd_d = vector_read_chan_b_in ? vec_mod : vector_q;
      // hold the vector steady through the acknowledge
      if (ack_q) begin
         dout_d = dout_q;
      end else if (mctl_q[vdirq_pkg::MCTL_VIS_BIT] && !mctl_q[vdirq_pkg::MCTL_SWACK_BIT]) begin
         dout_d = vec_mod;
      end else begin
         dout_d = vector_q;
      end
   end

   // configuration registers
   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         vector_q <= vdirq_pkg::VECTOR_RESET;
         mctl_q <= vdirq_pkg::MCTL_RESET;
         enable_q <= vdirq_pkg::ENABLE_RESET;
      end else begin
         vector_q <= vector_d;
         mctl_q <= mctl_d;
         enable_q <= enable_d;
      end
   end

   // pending and in-service state
   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         pending_q <= '0;
         ius_q <= '0;
      end else begin
         pending_q <= pending_d;
         ius_q <= ius_d;
      end
   end

   // receive mode state
   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         special_q <= '0;
         first_done_q <= '0;
      end else begin
         special_q <= special_d;
         first_done_q <= first_done_d;
      end
   end

   // acknowledge and vector outputs
   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         ack_q <= 1'b0;
         ack_prev_q <= 1'b0;
         dout_q <= '0;
         vrd_q <= '0;
      end else begin
         ack_q <= ack_d;
         ack_prev_q <= ack_prev_d;
         dout_q <= dout_d;
         vrd_q <= vrd_d;
      end
   end

   always_comb begin
      irq_n_out = 1'b0;
      // open drain: pull low while requesting and not in acknowledge
      irq_n_oe_out = (|req_gate) && chain_enable_in && !ack_q;
      chain_enable_out = chain_enable_in && !(|ius_q)
         && !(ack_q && (|pending_q));
      data_out = dout_q;
      data_oe_out = ack_q && !rd_n_in && chain_enable_in && (|grant | |ius_q)
         && !(mctl_q[vdirq_pkg::MCTL_NV_BIT] && !mctl_q[vdirq_pkg::MCTL_SWACK_BIT]);
      vector_read_out = vrd_q;
      pending_read_out = pending_q;
      in_service_out = ius_q;
      rx_avail_out = {pending_q[vdirq_pkg::SRC_B_RX], pending_q[vdirq_pkg::SRC_A_RX]};
   end
endmodule

// File: vdirq_ctrl_monitor.sv
`timescale 1ns/1ns
module vdirq_ctrl_monitor (
   input wire logic clk_sys_in,
   input wire logic reset_n_in,
   input wire logic [7:0] master_ctrl_in,
   input wire logic master_ctrl_stb_in,
   input wire logic [5:0] source_enable_in,
   input wire logic source_enable_stb_in,
   input wire logic reset_highest_stb_in,
   input wire logic irq_ack_n_in,
   input wire logic vector_read_stb_in,
   input wire logic rd_n_in,
   input wire logic chain_enable_in,
   input wire logic irq_n_oe_out,
   input wire logic chain_enable_out,
   input wire logic data_oe_out,
   input wire logic [5:0] pending_read_out,
   input wire logic [5:0] in_service_out,
   input wire logic [1:0] rx_avail_out
);
   // shadow of the write-only enables
   logic [5:0] en_q;
   logic mie_q;
   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         en_q <= 6'h00;
         mie_q <= 1'b0;
      end else begin
         if (source_enable_stb_in) en_q <= source_enable_in;
         if (master_ctrl_stb_in) mie_q <= master_ctrl_in[vdirq_pkg::MCTL_MIE_BIT];
      end
   end
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!reset_n_in);
   a_irq_gated: assert property (
      irq_n_oe_out |-> chain_enable_in && (|pending_read_out))
      else $error("request without pending source or chain enable");
   a_pend_enabled: assert property (
      (pending_read_out & ~$past(pending_read_out) & ~en_q) == 6'h00)
      else $error("pending set for a disabled source");
   a_irq_global: assert property (irq_n_oe_out |-> mie_q)
      else $error("request while global enable is off");
   a_chain_out: assert property (chain_enable_out |-> chain_enable_in)
      else $error("chain out high while chain in low");
   a_service_blocks: assert property ((|in_service_out) |-> !chain_enable_out)
      else $error("chain out high while in service");
   a_vector_drive: assert property (
      data_oe_out |-> !rd_n_in && chain_enable_in && !irq_ack_n_in)
      else $error("vector driven outside acknowledge read");
   a_service_single: assert property (
      $onehot0(in_service_out & ~$past(in_service_out)))
      else $error("more than one in-service bit set at once");
   a_reset_highest: assert property (
      reset_highest_stb_in && irq_ack_n_in && !vector_read_stb_in |=>
      in_service_out == ($past(in_service_out) & ($past(in_service_out) - 6'h01)))
      else $error("reset highest cleared the wrong bit");
   a_rx_polling: assert property (
      rx_avail_out == {pending_read_out[3], pending_read_out[0]})
      else $error("receive status does not follow pending");
endmodule
bind vdirq_ctrl vdirq_ctrl_monitor vdirq_ctrl_monitor_inst (.clk_sys_in, .reset_n_in,
   .master_ctrl_in, .master_ctrl_stb_in, .source_enable_in, .source_enable_stb_in,
   .reset_highest_stb_in, .irq_ack_n_in, .vector_read_stb_in, .rd_n_in, .chain_enable_in,
   .irq_n_oe_out, .chain_enable_out, .data_oe_out, .pending_read_out, .in_service_out,
   .rx_avail_out);

// File: vdirq_ctrl_tb.sv
`timescale 1ns/1ns
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; \
   $display("Error at %0t: got %h expected %h", $time, g, e); end end
module vdirq_ctrl_tb;
   logic clk_sys_in = 1'b0, reset_n_in = 1'b0, ack_go = 1'b0, busy = 1'b0, rd_seen = 1'b0;
   logic vector_write_stb_in = 1'b0, master_ctrl_stb_in = 1'b0, source_enable_stb_in = 1'b0;
   logic reset_highest_stb_in = 1'b0, vector_read_stb_in = 1'b0, vector_read_chan_b_in = 1'b0;
   logic [7:0] vector_write_in = 8'h00, master_ctrl_in = 8'h00, vec, got;
   logic [5:0] source_enable_in = 6'h00;
   vdirq_pkg::vdirq_rx_mode_t rx_mode_a_in = vdirq_pkg::VDIRQ_RX_OFF;
   vdirq_pkg::vdirq_rx_mode_t rx_mode_b_in = vdirq_pkg::VDIRQ_RX_ALL;
   vdirq_pkg::vdirq_chan_evt_t evt_a_in = '0, evt_b_in = '0;
   vdirq_pkg::vdirq_chan_clr_t clr_a_in = '0, clr_b_in = '0;
   logic irq_ack_n_in, rd_n_in, chain_enable_in, irq_n_out, irq_n_oe_out, chain_enable_out;
   logic data_oe_out;
   logic [7:0] data_out, vector_read_out, exp_q[$];
   logic [5:0] pending_read_out, in_service_out;
   logic [1:0] rx_avail_out;
   logic [31:0] seed = 32'h0dfbcc67;
   int fails = 0, comparisons = 0;
   int srcs[5] = '{0, 1, 2, 4, 5};
   logic [2:0] stat[5] = '{vdirq_pkg::VSTAT_A_RX, vdirq_pkg::VSTAT_A_TX,
      vdirq_pkg::VSTAT_A_EXT, vdirq_pkg::VSTAT_B_TX, vdirq_pkg::VSTAT_B_EXT};
   vdirq_ctrl vdirq_ctrl_inst (.clk_sys_in, .reset_n_in, .vector_write_in,
      .vector_write_stb_in, .master_ctrl_in, .master_ctrl_stb_in, .source_enable_in,
      .source_enable_stb_in, .rx_mode_a_in, .rx_mode_b_in, .evt_a_in, .evt_b_in, .clr_a_in,
      .clr_b_in, .reset_highest_stb_in, .vector_read_stb_in, .vector_read_chan_b_in,
      .irq_ack_n_in, .rd_n_in, .chain_enable_in, .irq_n_out, .irq_n_oe_out, .chain_enable_out,
      .data_out, .data_oe_out, .vector_read_out, .pending_read_out, .in_service_out,
      .rx_avail_out);
   vdirq_host_model vdirq_host_model_inst (.clk_sys_in, .ack_go_in(ack_go), .busy_in(busy),
      .irq_ack_n_out(irq_ack_n_in), .rd_n_out(rd_n_in), .chain_enable_out(chain_enable_in));
   initial forever #50 clk_sys_in = ~clk_sys_in;
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   task automatic give_verdict();
      if (fails == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge clk_sys_in);
   endtask
   task automatic strobe(input int which, input logic [7:0] v);
      case (which)
         0: begin vector_write_in = v; vector_write_stb_in = 1'b1; end
         1: begin master_ctrl_in = v; master_ctrl_stb_in = 1'b1; end
         2: begin source_enable_in = v[5:0]; source_enable_stb_in = 1'b1; end
         3: reset_highest_stb_in = 1'b1;
         default: begin vector_read_chan_b_in = v[0]; vector_read_stb_in = 1'b1; end
      endcase
      @(negedge clk_sys_in);
      {vector_write_stb_in, master_ctrl_stb_in, source_enable_stb_in} = 3'h0;
      {reset_highest_stb_in, vector_read_stb_in} = 2'h0;
   endtask
   // raise the event of source i, or its clear
   task automatic pulse_src(input int i, input logic clr);
      vdirq_pkg::vdirq_chan_evt_t e;
      vdirq_pkg::vdirq_chan_clr_t c;
      e = '0;
      c = '0;
      case (i % 3)
         0: begin e.rx_char = 1'b1; c.rx_clear = 1'b1; end
         1: begin e.tx_empty = 1'b1; c.tx_clear = 1'b1; end
         default: begin e.cts_edge = 1'b1; c.ext_clear = 1'b1; end
      endcase
      if (clr && i < 3) clr_a_in = c;
      else if (clr) clr_b_in = c;
      else if (i < 3) evt_a_in = e;
      else evt_b_in = e;
      @(negedge clk_sys_in);
      {evt_a_in, evt_b_in, clr_a_in, clr_b_in} = '0;
   endtask
   task automatic pulse_a(input logic [9:0] e, input logic [3:0] c);
      evt_a_in = e;
      clr_a_in = c;
      @(negedge clk_sys_in);
      evt_a_in = '0;
      clr_a_in = '0;
      idle(1);
   endtask
   task automatic wait_irq();
      int n;
      for (n = 0; n < 20 && irq_n_oe_out !== 1'b1; n++) @(negedge clk_sys_in);
      if (n == 20) begin
         fails++;
         give_verdict();
      end
   endtask
   always @(posedge clk_sys_in) rd_seen <= vector_read_stb_in;
   always @(negedge clk_sys_in) begin
      if (rd_seen) begin
         got = exp_q.pop_front();
         `CHK(vector_read_out, got)
      end
   end
   initial begin
      idle(10);
      reset_n_in = 1'b1;
      vec = rnd();
      strobe(0, vec);
      strobe(2, 8'h3f);
      pulse_src(1, 1'b0);
      idle(1);
      `CHK(irq_n_oe_out, 1'b0)
      `CHK(pending_read_out, 6'h02)
      strobe(1, 8'h29);
      strobe(2, 8'h3d);
      pulse_src(1, 1'b0);
      idle(1);
      `CHK(pending_read_out, 6'h00)
      strobe(2, 8'h3f);
      rx_mode_a_in = vdirq_pkg::VDIRQ_RX_ALL;
      foreach (srcs[k]) begin
         pulse_src(srcs[k], 1'b0);
         idle(1);
         `CHK(pending_read_out, 6'h01 << srcs[k])
         exp_q.push_back({vec[7:4], stat[k], vec[0]});
         strobe(4, 8'h01);
         idle(1);
         `CHK(in_service_out, 6'h01 << srcs[k])
         strobe(3, 8'h00);
         pulse_src(srcs[k], 1'b1);
         `CHK(in_service_out, 6'h00)
      end
      rx_mode_a_in = vdirq_pkg::VDIRQ_RX_FIRST;
      pulse_a(10'h000, 4'h1);
      pulse_a(10'h100, 4'h0);
      `CHK(pending_read_out, 6'h00)
      pulse_a(10'h200, 4'h0);
      `CHK(pending_read_out, 6'h01)
      `CHK(rx_avail_out, 2'h1)
      pulse_src(0, 1'b1);
      pulse_a(10'h200, 4'h0);
      `CHK(pending_read_out, 6'h00)
      pulse_a(10'h100, 4'h0);
      `CHK(pending_read_out, 6'h01)
      exp_q.push_back({vec[7:4], vdirq_pkg::VSTAT_A_SPC, vec[0]});
      strobe(4, 8'h01);
      idle(1);
      `CHK(in_service_out, 6'h01)
      strobe(3, 8'h00);
      pulse_src(0, 1'b1);
      `CHK(in_service_out, 6'h00)
      exp_q.push_back(vec);
      strobe(4, 8'h00);
      strobe(1, 8'h08);
      pulse_src(1, 1'b0);
      pulse_src(4, 1'b0);
      wait_irq();
      busy = 1'b1;
      idle(1);
      `CHK(irq_n_oe_out, 1'b0)
      `CHK(irq_n_out, 1'b0)
      busy = 1'b0;
      ack_go = 1'b1;
      idle(7);
      `CHK(in_service_out, 6'h02)
      `CHK({chain_enable_out, irq_n_oe_out, data_oe_out}, 3'h1)
      `CHK(data_out, vec)
      ack_go = 1'b0;
      idle(2);
      strobe(3, 8'h00);
      wait_irq();
      `CHK(pending_read_out, 6'h10)
      give_verdict();
   end
endmodule

// File: vdirq_host_model.sv
`timescale 1ns/1ns
module vdirq_host_model (
   input wire logic clk_sys_in,
   input wire logic ack_go_in,
   input wire logic busy_in,
   output logic irq_ack_n_out,
   output logic rd_n_out,
   output logic chain_enable_out
);
   logic [1:0] wait_q = 2'h0;
   // upstream device idle unless told busy
   assign chain_enable_out = !busy_in;
   initial begin
      irq_ack_n_out = 1'b1;
      rd_n_out = 1'b1;
   end
   always @(posedge clk_sys_in) begin
      irq_ack_n_out <= !ack_go_in;
      wait_q <= !ack_go_in ? 2'h0 : (wait_q == 2'h3) ? wait_q : wait_q + 2'h1;
      rd_n_out <= !(ack_go_in && wait_q == 2'h3);
   end
endmodule

// File: vdirq_pkg.sv
package vdirq_pkg;
   localparam int NUM_SRC = 6;
   localparam int VEC_W = 8;
   // source index, highest priority first
   localparam logic [2:0] SRC_A_RX = 3'h0;
   localparam logic [2:0] SRC_A_TX = 3'h1;
   localparam logic [2:0] SRC_A_EXT = 3'h2;
   localparam logic [2:0] SRC_B_RX = 3'h3;
   localparam logic [2:0] SRC_B_TX = 3'h4;
   localparam logic [2:0] SRC_B_EXT = 3'h5;
   // master control field positions
   localparam int MCTL_VIS_BIT = 0;
   localparam int MCTL_NV_BIT = 1;
   localparam int MCTL_MIE_BIT = 3;
   localparam int MCTL_SWACK_BIT = 5;
   localparam logic [7:0] MCTL_RESET = 8'h00;
   localparam logic [7:0] VECTOR_RESET = 8'h00;
   localparam logic [5:0] ENABLE_RESET = 6'h00;
   // vector status field, three bits replaced
   localparam int VSTAT_LSB = 1;
   localparam int VSTAT_W = 3;
   localparam logic [2:0] VSTAT_NONE = 3'h3;
   localparam logic [2:0] VSTAT_B_TX = 3'h0;
   localparam logic [2:0] VSTAT_B_EXT = 3'h1;
   localparam logic [2:0] VSTAT_B_RX = 3'h2;
   localparam logic [2:0] VSTAT_B_SPC = 3'h3;
   localparam logic [2:0] VSTAT_A_TX = 3'h4;
   localparam logic [2:0] VSTAT_A_EXT = 3'h5;
   localparam logic [2:0] VSTAT_A_RX = 3'h6;
   localparam logic [2:0] VSTAT_A_SPC = 3'h7;
   // receive interrupt modes
   typedef enum logic [1:0] {
      VDIRQ_RX_OFF,
      VDIRQ_RX_FIRST,
      VDIRQ_RX_ALL,
      VDIRQ_RX_SPECIAL
   } vdirq_rx_mode_t;
   // per-channel events from the protocol engines
   typedef struct packed {
      logic rx_char;
      logic rx_special;
      logic tx_empty;
      logic cts_edge;
      logic dcd_edge;
      logic sync_edge;
      logic tx_underrun;
      logic baud_zero;
      logic brk_abort_eop_start;
      logic brk_abort_eop_end;
   } vdirq_chan_evt_t;
   // per-channel acknowledges from software
   typedef struct packed {
      logic rx_clear;
      logic tx_clear;
      logic ext_clear;
      logic first_rearm;
   } vdirq_chan_clr_t;
endpackage
